/* File: hw/caf_pkg.sv */
// caf_pkg: constants for the receive acceptance filter block.
// assumes 16-bit register words reached over a plain address/strobe port.
package caf_pkg;
  localparam int NUM_FILT = 16;
  localparam int NUM_PAIR = 8;
  localparam int IDX_W    = 4;
  localparam int PTR_W    = 5;
  localparam int SID_W    = 12;
  localparam int EID_W    = 18;
  localparam int DATA_W   = 16;
  localparam int REG_W    = 16;
  localparam int ADDR_W   = 8;
  localparam int GRP_MSB  = 7;
  localparam int GRP_LSB  = 4;
  localparam int IDX_MSB  = 3;

  // register groups, selected by the upper address nibble
  localparam logic [3:0] GRP_CTRL = 4'h0;
  localparam logic [3:0] GRP_IDH  = 4'h1;
  localparam logic [3:0] GRP_IDL  = 4'h2;
  localparam logic [3:0] GRP_MKH  = 4'h3;
  localparam logic [3:0] GRP_MKL  = 4'h4;
  localparam logic [3:0] GRP_MISC = 4'h5;
  localparam logic [ADDR_W-1:0] CTRL_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] IDH_BASE  = 8'h10;
  localparam logic [ADDR_W-1:0] IDL_BASE  = 8'h20;
  localparam logic [ADDR_W-1:0] MKH_BASE  = 8'h30;
  localparam logic [ADDR_W-1:0] MKL_BASE  = 8'h40;
  localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h50;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h51;

  // control word: odd filter in upper byte, even filter in lower byte
  localparam int ODD_EN_BIT  = 15;
  localparam int ODD_PTR_LSB = 8;
  localparam int EVN_EN_BIT  = 7;
  localparam int EVN_PTR_LSB = 0;
  // high word: type bit, sid bit 11, eid 17..5
  localparam int HI_TYPE_BIT  = 14;
  localparam int HI_STD_ID_BIT11_FILTER_BIT = 13;
  localparam int HI_EID_MSB   = 12;
  // low word: eid 4..0 on top, sid 10..0 below
  localparam int LO_EID_MSB = 15;
  localparam int LO_EID_LSB = 11;
  localparam int LO_SID_MSB = 10;
  localparam int MODE_BYTE_BIT = 0;
  // status word layout
  localparam int ST_HIT_BIT  = 15;
  localparam int ST_OBJ_LSB  = 8;

  localparam logic [REG_W-1:0] CTRL_WMASK = 16'h9f9f;
  localparam logic [REG_W-1:0] HI_WMASK   = 16'h7fff;
  localparam logic [REG_W-1:0] LO_WMASK   = 16'hffff;
  localparam logic [REG_W-1:0] MODE_WMASK = 16'h0001;
  localparam logic [REG_W-1:0] RST_WORD   = 16'h0000;
endpackage

/* File: hw/caf_frame_if.sv */
// caf_frame_if: received frame fields fanned out to the filter compares.
// assumes the top drives it from the protocol engine inputs, with byte_mode from the mode register.
`timescale 1ns/1ps
`default_nettype none
interface caf_frame_if;
  logic                        ext;
  logic                        byte_mode;
  logic [caf_pkg::SID_W-1:0]   std_id_filter;
  logic [caf_pkg::EID_W-1:0]   ext_id_filter;
  logic [caf_pkg::DATA_W-1:0]  data;
  modport src (output ext, output byte_mode, output std_id_filter, output ext_id_filter, output data);
  modport dst (input ext, input byte_mode, input std_id_filter, input ext_id_filter, input data);
endinterface
`default_nettype wire

/* File: hw/caf_filter_cmp.sv */
// caf_filter_cmp: one filter/mask compare against the frame on the interface.
// assumes filter and mask words are already masked to their writable bits.
`timescale 1ns/1ps
`default_nettype none
module caf_filter_cmp (
  caf_frame_if.dst                   frm,
  input  wire logic                  enable,
  input  wire logic [15:0]           fil_hi,
  input  wire logic [15:0]           fil_lo,
  input  wire logic [15:0]           msk_hi,
  input  wire logic [15:0]           msk_lo,
  output logic                       hit
);
  logic [caf_pkg::SID_W-1:0]  f_sid;
  logic [caf_pkg::SID_W-1:0]  m_sid;
  logic [caf_pkg::EID_W-1:0]  f_eid;
  logic [caf_pkg::EID_W-1:0]  m_eid;
  logic                       sid_ok;
  logic                       eid_ok;
  logic                       type_ok;

  assign f_sid = {fil_hi[caf_pkg::HI_STD_ID_BIT11_FILTER_BIT], fil_lo[caf_pkg::LO_SID_MSB:0]};
  assign m_sid = {msk_hi[caf_pkg::HI_STD_ID_BIT11_FILTER_BIT], msk_lo[caf_pkg::LO_SID_MSB:0]};
  assign f_eid = {fil_hi[caf_pkg::HI_EID_MSB:0],
                  fil_lo[caf_pkg::LO_EID_MSB:caf_pkg::LO_EID_LSB]};
  assign m_eid = {msk_hi[caf_pkg::HI_EID_MSB:0],
                  msk_lo[caf_pkg::LO_EID_MSB:caf_pkg::LO_EID_LSB]};

  // mask bit 0 makes the identifier bit a don't-care
  assign sid_ok = ((f_sid ^ frm.std_id_filter) & m_sid) == '0;

  always_comb begin
    if (frm.byte_mode) begin
      // eid field bits 15..0 stand against data bytes 0 and 1
      eid_ok = ((f_eid[caf_pkg::DATA_W-1:0] ^ frm.data)
                & m_eid[caf_pkg::DATA_W-1:0]) == '0;
    end else if (frm.ext) begin
      eid_ok = ((f_eid ^ frm.ext_id_filter) & m_eid) == '0;
    end else begin
      eid_ok = 1'b1;
    end
  end

  // type bit clear accepts either format
  assign type_ok = !msk_hi[caf_pkg::HI_TYPE_BIT]
                   || (fil_hi[caf_pkg::HI_TYPE_BIT] == frm.ext);

  assign hit = enable && sid_ok && eid_ok && type_ok;
endmodule // caf_filter_cmp
`default_nettype wire

/* File: hw/caf_select.sv */
// caf_select: picks the lowest-numbered hitting filter and registers the result.
// assumes hit and pointer vectors are valid in the frame-valid cycle.
`timescale 1ns/1ps
`default_nettype none
module caf_select (
  input  wire logic                                      mclk,
  input  wire logic                                      rst_n,
  input  wire logic                                      frame_valid,
  input  wire logic [caf_pkg::NUM_FILT-1:0]              hits,
  input  wire logic [caf_pkg::NUM_FILT-1:0][caf_pkg::PTR_W-1:0] ptrs,
  output logic                                           acc_valid,
  output logic                                           acc_hit,
  output logic [caf_pkg::IDX_W-1:0]                      acc_filter,
  output logic [caf_pkg::PTR_W-1:0]                      acc_object
);
  logic [caf_pkg::IDX_W-1:0] next_filter;

  // walk down so the lowest index wins
  always_comb begin
    next_filter = '0;
    for (int i = caf_pkg::NUM_FILT - 1; i >= 0; i--) begin
      if (hits[i]) begin
        next_filter = i[caf_pkg::IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_valid  <= 1'b0;
      acc_hit    <= 1'b0;
      acc_filter <= '0;
      acc_object <= '0;
    end else begin
      acc_valid <= frame_valid;
      acc_hit   <= frame_valid && (hits != '0);
      if (frame_valid && (hits != '0)) begin
        acc_filter <= next_filter;
        acc_object <= ptrs[next_filter];
      end
    end
  end
endmodule // caf_select
`default_nettype wire

/* File: hw/caf_top.sv */
// caf_top: sixteen-entry receive acceptance filter with register port.
// assumes frame fields from the protocol engine are synchronous to mclk.
// Notes on behaviour
// - sixteen filters, each with id and mask
// - per-filter enable; cleared filter never accepts
// - hit routes message to pointer-selected object
// - pair control word layout, unused bits zero
// - filter high word: type, std_id_bit11_filter, eid17-5
// - filter low word: eid4-0, sid10-0
// - type bit set: extended flag picks format
// - type bit set: format must equal flag
// - type bit clear: both formats accepted
// - sid must match; extended also eid
// - mask high word: type, std_id_bit11_filter, eid17-5
// - mask low word: eid4-0, sid10-0
// - byte mode: eid filter compares data bytes
// - byte mode: eid mask covers data bytes
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module caf_top (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [caf_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [caf_pkg::REG_W-1:0]     reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [caf_pkg::REG_W-1:0]     reg_rdata,
  input  wire logic                          rx_valid,
  input  wire logic                          rx_ext,
  input  wire logic [caf_pkg::SID_W-1:0]     rx_sid,
  input  wire logic [caf_pkg::EID_W-1:0]     rx_eid,
  input  wire logic [caf_pkg::DATA_W-1:0]    rx_data,
  output logic                               acc_valid,
  output logic                               acc_hit,
  output logic      [caf_pkg::IDX_W-1:0]     acc_filter,
  output logic      [caf_pkg::PTR_W-1:0]     acc_object
);
  logic [caf_pkg::REG_W-1:0] ctrl_pair [caf_pkg::NUM_PAIR];
  logic [caf_pkg::REG_W-1:0] filter_id_high [caf_pkg::NUM_FILT];
  logic [caf_pkg::REG_W-1:0] filter_id_low [caf_pkg::NUM_FILT];
  logic [caf_pkg::REG_W-1:0] filter_mask_high [caf_pkg::NUM_FILT];
  logic [caf_pkg::REG_W-1:0] filter_mask_low [caf_pkg::NUM_FILT];
  logic [caf_pkg::REG_W-1:0] mode;
  logic [caf_pkg::REG_W-1:0] next_rdata;

  logic [caf_pkg::NUM_FILT-1:0]                        filt_en;
  logic [caf_pkg::NUM_FILT-1:0][caf_pkg::PTR_W-1:0]    filt_ptr;
  logic [caf_pkg::NUM_FILT-1:0]                        hits;
  logic [3:0]                                          grp;
  logic [caf_pkg::IDX_MSB:0]                           idx;
  logic [caf_pkg::IDX_MSB-1:0]                         pidx;

  caf_frame_if frm ();

  assign grp  = reg_addr[caf_pkg::GRP_MSB:caf_pkg::GRP_LSB];
  assign idx  = reg_addr[caf_pkg::IDX_MSB:0];
  assign pidx = reg_addr[caf_pkg::IDX_MSB-1:0];

  assign frm.ext       = rx_ext;
  assign frm.byte_mode = mode[caf_pkg::MODE_BYTE_BIT];
  assign frm.std_id_filter       = rx_sid;
  assign frm.ext_id_filter       = rx_eid;
  assign frm.data      = rx_data;

  // control pair words; unused bits never stored so they read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < caf_pkg::NUM_PAIR; k++) begin
        ctrl_pair[k] <= caf_pkg::RST_WORD;
      end
    end else if (reg_wr && grp == caf_pkg::GRP_CTRL && !reg_addr[caf_pkg::IDX_MSB]) begin
      ctrl_pair[pidx] <= reg_wdata & caf_pkg::CTRL_WMASK;
    end
  end

  // filter id words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
        filter_id_high[k] <= caf_pkg::RST_WORD;
        filter_id_low[k]  <= caf_pkg::RST_WORD;
      end
    end else if (reg_wr && grp == caf_pkg::GRP_IDH) begin
      filter_id_high[idx] <= reg_wdata & caf_pkg::HI_WMASK;
    end else if (reg_wr && grp == caf_pkg::GRP_IDL) begin
      filter_id_low[idx] <= reg_wdata & caf_pkg::LO_WMASK;
    end
  end

  // mask words
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < caf_pkg::NUM_FILT; k++) begin
        filter_mask_high[k] <= caf_pkg::RST_WORD;
        filter_mask_low[k]  <= caf_pkg::RST_WORD;
      end
    end else if (reg_wr && grp == caf_pkg::GRP_MKH) begin
      filter_mask_high[idx] <= reg_wdata & caf_pkg::HI_WMASK;
    end else if (reg_wr && grp == caf_pkg::GRP_MKL) begin
      filter_mask_low[idx] <= reg_wdata & caf_pkg::LO_WMASK;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= caf_pkg::RST_WORD;
    end else if (reg_wr && reg_addr == caf_pkg::MODE_ADDR) begin
      mode <= reg_wdata & caf_pkg::MODE_WMASK;
    end
  end

  // read mux; status holds object and filter of the last accepted frame, hit bit only in the cycle after a frame
  always_comb begin
    next_rdata = '0;
    case (grp)
      caf_pkg::GRP_CTRL: begin
        if (!reg_addr[caf_pkg::IDX_MSB]) begin
          next_rdata = ctrl_pair[pidx];
        end
      end
      caf_pkg::GRP_IDH: next_rdata = filter_id_high[idx];
      caf_pkg::GRP_IDL: next_rdata = filter_id_low[idx];
      caf_pkg::GRP_MKH: next_rdata = filter_mask_high[idx];
      caf_pkg::GRP_MKL: next_rdata = filter_mask_low[idx];
      caf_pkg::GRP_MISC: begin
        if (reg_addr == caf_pkg::MODE_ADDR) begin
          next_rdata = mode;
        end else if (reg_addr == caf_pkg::STAT_ADDR) begin
          next_rdata[caf_pkg::ST_HIT_BIT] = acc_hit;
          next_rdata[caf_pkg::ST_OBJ_LSB +: caf_pkg::PTR_W] = acc_object;
          next_rdata[caf_pkg::IDX_W-1:0] = acc_filter;
        end
      end
      default: next_rdata = '0;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < caf_pkg::NUM_FILT; gi++) begin : g_filt
      if (gi % 2 == 1) begin : g_odd
        assign filt_en[gi]  = ctrl_pair[gi/2][caf_pkg::ODD_EN_BIT];
        assign filt_ptr[gi] = ctrl_pair[gi/2][caf_pkg::ODD_PTR_LSB +: caf_pkg::PTR_W];
      end else begin : g_even
        assign filt_en[gi]  = ctrl_pair[gi/2][caf_pkg::EVN_EN_BIT];
        assign filt_ptr[gi] = ctrl_pair[gi/2][caf_pkg::EVN_PTR_LSB +: caf_pkg::PTR_W];
      end
      caf_filter_cmp u_cmp (
        .frm    (frm.dst),
        .enable (filt_en[gi]),
        .fil_hi (filter_id_high[gi]),
        .fil_lo (filter_id_low[gi]),
        .msk_hi (filter_mask_high[gi]),
        .msk_lo (filter_mask_low[gi]),
        .hit    (hits[gi])
      );
    end
  endgenerate

  // pointer passes through unchecked; reserved codes and object zero are software's to avoid
  caf_select u_sel (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .frame_valid (rx_valid),
    .hits        (hits),
    .ptrs        (filt_ptr),
    .acc_valid   (acc_valid),
    .acc_hit     (acc_hit),
    .acc_filter  (acc_filter),
    .acc_object  (acc_object)
  );

  // helper view of filter 0 for checking
  logic [caf_pkg::SID_W-1:0] f0_sid;
  logic [caf_pkg::SID_W-1:0] m0_sid;
  logic [caf_pkg::EID_W-1:0] f0_eid;
  logic [caf_pkg::EID_W-1:0] m0_eid;
  assign f0_sid = {filter_id_high[0][caf_pkg::HI_STD_ID_BIT11_FILTER_BIT],
                   filter_id_low[0][caf_pkg::LO_SID_MSB:0]};
  assign m0_sid = {filter_mask_high[0][caf_pkg::HI_STD_ID_BIT11_FILTER_BIT],
                   filter_mask_low[0][caf_pkg::LO_SID_MSB:0]};
  assign f0_eid = {filter_id_high[0][caf_pkg::HI_EID_MSB:0],
                   filter_id_low[0][caf_pkg::LO_EID_MSB:caf_pkg::LO_EID_LSB]};
  assign m0_eid = {filter_mask_high[0][caf_pkg::HI_EID_MSB:0],
                   filter_mask_low[0][caf_pkg::LO_EID_MSB:caf_pkg::LO_EID_LSB]};

  a_disabled_no_hit: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rx_valid && filt_en == '0) |=> (acc_valid && !acc_hit))
    else $error("hit reported with every filter disabled");

  a_hit_object_route: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (rx_valid && hits[0]) |=> (acc_hit && acc_filter == '0
                               && acc_object == $past(filt_ptr[0])))
    else $error("filter 0 hit not routed to its object");

  a_ctrl_unused_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && grp == caf_pkg::GRP_CTRL) |=> ((reg_rdata & ~caf_pkg::CTRL_WMASK) == '0))
    else $error("control word unused bits not zero");

  a_high_bit15_zero: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (reg_rd && (grp == caf_pkg::GRP_IDH || grp == caf_pkg::GRP_MKH))
      |=> ((reg_rdata & ~caf_pkg::HI_WMASK) == '0))
    else $error("high word bit 15 not zero");

  a_low_readback: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == caf_pkg::IDL_BASE) ##1 (reg_rd && reg_addr == caf_pkg::IDL_BASE)
      |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("filter low word readback mismatch");

  a_type_gate: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (hits[0] && filter_mask_high[0][caf_pkg::HI_TYPE_BIT])
      |-> (filter_id_high[0][caf_pkg::HI_TYPE_BIT] == rx_ext))
    else $error("frame format accepted against type selection");

  a_sid_masked_match: assert property (
    @(posedge mclk) disable iff (!rst_n)
    hits[0] |-> (((f0_sid ^ rx_sid) & m0_sid) == '0))
    else $error("hit with masked sid mismatch");

  a_byte_mode_data: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (hits[0] && mode[caf_pkg::MODE_BYTE_BIT])
      |-> (((f0_eid[caf_pkg::DATA_W-1:0] ^ rx_data) & m0_eid[caf_pkg::DATA_W-1:0]) == '0))
    else $error("byte mode hit with data mismatch");

  a_ext_eid_match: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (hits[0] && rx_ext && !mode[caf_pkg::MODE_BYTE_BIT])
      |-> (((f0_eid ^ rx_eid) & m0_eid) == '0))
    else $error("extended hit with eid mismatch");

  c_std_accept: cover property (@(posedge mclk) disable iff (!rst_n)
    rx_valid && !rx_ext && hits != '0);
  c_ext_accept: cover property (@(posedge mclk) disable iff (!rst_n)
    rx_valid && rx_ext && hits != '0);
  c_multi_hit: cover property (@(posedge mclk) disable iff (!rst_n)
    rx_valid && hits[0] && hits[1]);
  c_byte_mode: cover property (@(posedge mclk) disable iff (!rst_n)
    rx_valid && mode[caf_pkg::MODE_BYTE_BIT] && hits != '0);
endmodule // caf_top
`default_nettype wire

/* File: tb/caf_rx_engine.sv */
// caf_rx_engine: behavioural receive engine handing frame ids to the filter.
// assumes mclk from the bench; one frame per send call, any gap before it.
`timescale 1ns/1ps
`default_nettype none
module caf_rx_engine (
  input  wire logic                        mclk,
  output logic                             rx_valid,
  output logic                             rx_ext,
  output logic [caf_pkg::SID_W-1:0]        rx_sid,
  output logic [caf_pkg::EID_W-1:0]        rx_eid,
  output logic [caf_pkg::DATA_W-1:0]       rx_data
);
  logic                       pend = 1'b0;
  logic                       q_ext;
  logic [caf_pkg::SID_W-1:0]  q_sid;
  logic [caf_pkg::EID_W-1:0]  q_eid;
  logic [caf_pkg::DATA_W-1:0] q_data;

  initial begin
    rx_valid = 1'b0;
    rx_ext   = 1'b0;
    rx_sid   = 12'h000;
    rx_eid   = 18'h00000;
    rx_data  = 16'h0000;
  end

  // fields churn outside a frame, so reading them then gives garbage
  always @(posedge mclk) begin
    if (pend) begin
      rx_valid <= 1'b1;
      rx_ext   <= q_ext;
      rx_sid   <= q_sid;
      rx_eid   <= q_eid;
      rx_data  <= q_data;
      pend = 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_ext   <= ~rx_ext;
      rx_sid   <= ~rx_sid;
      rx_eid   <= ~rx_eid;
      rx_data  <= ~rx_data;
    end
  end

  // returns in the time step of the edge that launches the frame
  task automatic send(input logic e, input logic [11:0] s, input logic [17:0] x,
                      input logic [15:0] d, input int gap);
    repeat (gap) @(posedge mclk);
    #1;
    q_ext  = e;
    q_sid  = s;
    q_eid  = x;
    q_data = d;
    pend   = 1'b1;
    wait (pend == 1'b0);
  endtask
endmodule // caf_rx_engine
`default_nettype wire

/* File: tb/caf_tb_top.sv */
// caf_tb_top: self-checking bench for the acceptance filter top.
// assumes caf_pkg compiled first; frames come from caf_rx_engine.
`timescale 1ns/1ps
`default_nettype none
module caf_tb_top;
  localparam int LIMIT = 5000;
  typedef struct packed {
    logic ext; logic [11:0] std_id_filter; logic [17:0] ext_id_filter; logic hit; logic [3:0] flt; logic [4:0] obj;
  } caf_row_s;
  typedef struct packed {
    logic [3:0] n; logic [15:0] ih; logic [15:0] il; logic [15:0] mh; logic [15:0] ml;
  } caf_cfg_s;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic        reg_wr;
  logic        reg_rd;
  logic        rx_valid;
  logic        rx_ext;
  logic [11:0] rx_sid;
  logic [17:0] rx_eid;
  logic [15:0] rx_data;
  logic        acc_valid;
  logic        acc_hit;
  logic [3:0]  acc_filter;
  logic [4:0]  acc_object;
  int          fails;
  int          n_tests;
  int          cyc = 0;
  logic [7:0]  lay_a [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h08, 8'h50};
  logic [15:0] lay_w [7] = '{16'hf2f1, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] lay_e [7] = '{16'h9291, 16'h7fff, 16'hffff, 16'h7fff, 16'hffff, 16'h0000, 16'h0001};
  caf_cfg_s cfg [6] = '{'{4'h0, 16'h0000, 16'h0123, 16'h6000, 16'h07ff},
                        '{4'h1, 16'h0000, 16'h0123, 16'h6000, 16'h07ff},
                        '{4'h2, 16'h555e, 16'h6c56, 16'h7fff, 16'hffff},
                        '{4'h3, 16'h0000, 16'h03f0, 16'h0000, 16'h07f0},
                        '{4'he, 16'h0000, 16'h07ff, 16'h2000, 16'h07ff},
                        '{4'hf, 16'h2000, 16'h07ff, 16'h2000, 16'h07ff}};
  caf_row_s rows [12] = '{'{1'b0, 12'h123, 18'h00000, 1'b1, 4'h1, 5'h02},
                          '{1'b1, 12'h123, 18'h00000, 1'b0, 4'h0, 5'h00},
                          '{1'b1, 12'h456, 18'h2abcd, 1'b1, 4'h2, 5'h03},
                          '{1'b1, 12'h456, 18'h2abcc, 1'b0, 4'h0, 5'h00},
                          '{1'b1, 12'h456, 18'h0abcd, 1'b0, 4'h0, 5'h00},
                          '{1'b0, 12'h456, 18'h00000, 1'b0, 4'h0, 5'h00},
                          '{1'b0, 12'h3f5, 18'h00000, 1'b1, 4'h3, 5'h04},
                          '{1'b1, 12'h3fa, 18'h3ffff, 1'b1, 4'h3, 5'h04},
                          '{1'b0, 12'hbf0, 18'h00000, 1'b1, 4'h3, 5'h04},
                          '{1'b0, 12'h3e0, 18'h00000, 1'b0, 4'h0, 5'h00},
                          '{1'b0, 12'hfff, 18'h00000, 1'b1, 4'hf, 5'h07},
                          '{1'b0, 12'h7ff, 18'h00000, 1'b1, 4'he, 5'h06}};

  caf_top uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_ext(rx_ext), .rx_sid(rx_sid), .rx_eid(rx_eid), .rx_data(rx_data),
    .acc_valid(acc_valid), .acc_hit(acc_hit), .acc_filter(acc_filter),
    .acc_object(acc_object));
  caf_rx_engine eng (.mclk(mclk), .rx_valid(rx_valid), .rx_ext(rx_ext), .rx_sid(rx_sid),
    .rx_eid(rx_eid), .rx_data(rx_data));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk(what, exp, rd_val);
  endtask

  // write then read the same word with no idle cycle between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk("layout", exp, rd_val);
  endtask

  task automatic chk_acc(input logic h, input logic [3:0] f, input logic [4:0] o);
    chk("acc_valid", 16'h0001, 16'(acc_valid));
    chk("acc_hit", 16'(h), 16'(acc_hit));
    if (h) begin
      chk("acc_filter", 16'(f), 16'(acc_filter));
      chk("acc_object", 16'(o), 16'(acc_object));
    end
  endtask

  task automatic frame(input logic e, input logic [11:0] s, input logic [17:0] x,
                       input logic [15:0] d, input int gap, input logic h,
                       input logic [3:0] f, input logic [4:0] o);
    eng.send(e, s, x, d, gap);
    @(posedge mclk);
    #1 chk_acc(h, f, o);
  endtask

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    n_tests = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 'h52; a++) rchk("reset word", 8'(a), 16'h0000);
    frame(1'b0, 12'h123, 18'h0, 16'h0, 0, 1'b0, 4'h0, 5'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      wrrd(lay_a[i], lay_w[i], lay_e[i]);
    end
    @(posedge mclk);
    #1 chk("rdata idle", 16'h0000, reg_rdata);
    $display("test layout done");
    wr(caf_pkg::MODE_ADDR, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(caf_pkg::IDH_BASE + 8'(cfg[i].n), cfg[i].ih);
      wr(caf_pkg::IDL_BASE + 8'(cfg[i].n), cfg[i].il);
      wr(caf_pkg::MKH_BASE + 8'(cfg[i].n), cfg[i].mh);
      wr(caf_pkg::MKL_BASE + 8'(cfg[i].n), cfg[i].ml);
    end
    // pointers stay within objects 1..7
    wr(8'h00, 16'h8201);
    wr(8'h01, 16'h8483);
    wr(8'h07, 16'h8786);
    for (int i = 0; i < 12; i++) begin
      frame(rows[i].ext, rows[i].std_id_filter, rows[i].ext_id_filter, 16'h0, i % 3, rows[i].hit, rows[i].flt,
            rows[i].obj);
    end
    $display("test table done");
    // two frames on consecutive cycles
    eng.send(1'b1, 12'h456, 18'h2abcd, 16'h0, 0);
    eng.send(1'b0, 12'hfff, 18'h0, 16'h0, 0);
    #1 chk_acc(1'b1, 4'h2, 5'h03);
    @(posedge mclk);
    #1 chk_acc(1'b1, 4'hf, 5'h07);
    // enabling filter 0 makes it win over filter 1
    wr(8'h00, 16'h8281);
    frame(1'b0, 12'h123, 18'h0, 16'h0, 1, 1'b1, 4'h0, 5'h01);
    // hit flag is a one-cycle pulse, object and filter hold
    rchk("status", caf_pkg::STAT_ADDR, 16'h0100);
    $display("test back to back done");
    wr(caf_pkg::MODE_ADDR, 16'h0001);
    rchk("mode", caf_pkg::MODE_ADDR, 16'h0001);
    frame(1'b1, 12'h456, 18'h0, 16'habcd, 0, 1'b1, 4'h2, 5'h03);
    frame(1'b1, 12'h456, 18'h2abcd, 16'habcc, 2, 1'b0, 4'h0, 5'h00);
    $display("test byte mode done");
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rchk("ctrl after reset", 8'h01, 16'h0000);
    rchk("mode after reset", caf_pkg::MODE_ADDR, 16'h0000);
    frame(1'b0, 12'h123, 18'h0, 16'h0, 0, 1'b0, 4'h0, 5'h00);
    $display("test mid reset done");
    stop_test();
  end
endmodule // caf_tb_top
`default_nettype wire
